// File: tb_vr_power_monitor_regs.sv
`timescale 1ns/10ps
module tb_vr_power_monitor_regs;
   import vpm_pkg::*;

   localparam logic [1:0] ICC = 2'b01; // 2 A/step strap
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   vpm_req_type regReq;
   logic [7:0] regRdData;
   logic regRdValid;
   logic [7:0] sysPowerInput = 8'h00;
   logic deepestLowPowerState = 1'b0;
   logic cycleCurrentLimitPin = 1'b0;
   logic [7:0] voltageCode = 8'h00;
   logic coarseTable = 1'b0;
   logic [11:0] voltageMv;
   logic [7:0] multiRegulatorConfig;
   logic regulatorOverheatAlertN;
   int errors = 0;
   int cmp_count = 0;
   int seed = 80801;
   int mdl [256]; // register image kept by the bench
   int k;
   logic [7:0] code;
   logic [7:0] rwAddr [6] = '{8'h34, 8'h49, 8'h4a, 8'h4b, 8'h4c, 8'h4f};

   // clock at 100 ns
   initial begin
      forever #50 sys_clk = ~sys_clk;
   end

   // one tick per clock keeps the timers short
   vpm_power_monitor_regs #(.ICC_SCALE(ICC), .TICK_CYC(1))
   u_vpm_power_monitor_regs (
      .sys_clk(sys_clk), .rst_n(rst_n), .regReq(regReq),
      .regRdData(regRdData), .regRdValid(regRdValid),
      .sysPowerInput(sysPowerInput),
      .deepestLowPowerState(deepestLowPowerState),
      .cycleCurrentLimitPin(cycleCurrentLimitPin),
      .voltageCode(voltageCode), .coarseTable(coarseTable),
      .voltageMv(voltageMv), .multiRegulatorConfig(multiRegulatorConfig),
      .regulatorOverheatAlertN(regulatorOverheatAlertN));

   vpm_bus_master u_vpm_bus_master (
      .sys_clk(sys_clk), .regReq(regReq),
      .regRdData(regRdData), .regRdValid(regRdValid));

   // compare and count, report at once
   task automatic check(input logic [11:0] got, input logic [11:0] exp,
                        input string what);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      u_vpm_bus_master.doWrite(a, d);
      mdl[a] = d;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic ok;
      u_vpm_bus_master.doRead(a, d, ok);
      check({11'h000, ok}, 12'h001, "read valid");
      check({4'h0, d}, {4'h0, exp}, $sformatf("read %h", a));
   endtask

   // smallest exponent encoding, lower bits dropped
   function automatic logic [7:0] enc(input int c);
      for (int e = 0; e < 16; e++) begin
         if ((c >> e) <= 15) begin
            return 8'(((c >> e) << 4) | e);
         end
      end
      return 8'hff;
   endfunction

   // millivolts expected for a code
   function automatic logic [11:0] vexp(input int c, input int coarse);
      if (c == 0) begin
         return 12'h000;
      end
      return 12'(coarse ? 200 + (c - 1) * 10 : 250 + (c - 1) * 5);
   endfunction

   // run above a level for a number of cycles, then drop
   task automatic above(input logic [7:0] v, input int n);
      sysPowerInput = v;
      cyc(n);
      sysPowerInput = 8'h00;
      cyc(2);
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // hang guard, far beyond the under one thousand cycles the tests need
   initial begin
      #3000000;
      errors++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      report_and_stop;
   end

   initial begin
      cyc(16);
      rst_n = 1'b1;
      cyc(3);
      // reset values, read-only strap and an unmapped index
      check(multiRegulatorConfig, 12'h001, "cfg port");
      rd(8'h34, 8'h01);
      for (int i = 1; i < 6; i++) rd(rwAddr[i], 8'h00);
      rd(8'h50, {6'h00, ICC});
      rd(8'h60, 8'h00);
      // random write and read back of every writable register
      for (int i = 0; i < 6; i++) wr(rwAddr[i], 8'($random(seed)));
      for (int i = 0; i < 6; i++) rd(rwAddr[i], 8'(mdl[rwAddr[i]]));
      check(multiRegulatorConfig, 12'(mdl[8'h34]), "cfg port");
      rd(8'h35, 8'h4f);
      wr(8'h50, 8'hff);
      rd(8'h50, {6'h00, ICC});
      rd(8'h35, 8'h50);
      $display("test registers done");

      // warning timers: warn1 low, warn2 high
      wr(8'h4c, 8'h40);
      wr(8'h4b, 8'hc0);
      rd(8'h4e, 8'h00);
      rd(8'h4d, 8'h00);
      above(8'h40, 100);
      rd(8'h4e, 8'h00);
      above(8'h80, 100);
      rd(8'h4e, enc(100));
      rd(8'h4d, 8'h00);
      rd(8'h4e, 8'h00);
      above(8'h80, 100);
      wr(8'h4c, 8'h40); // same value leaves the count
      rd(8'h4e, enc(100));
      above(8'hd0, 100);
      wr(8'h4b, 8'hc1); // changed value clears
      rd(8'h4d, 8'h00);
      rd(8'h4e, enc(100));
      // deepest low-power state freezes the count
      sysPowerInput = 8'h80;
      cyc(100);
      deepestLowPowerState = 1'b1;
      cyc(50);
      rd(8'h4e, enc(100));
      wr(8'h4c, 8'h42);
      rd(8'h4e, enc(100));
      sysPowerInput = 8'h00;
      cyc(2);
      deepestLowPowerState = 1'b0;
      rd(8'h4e, enc(100));
      rd(8'h4e, 8'h00);
      $display("test warning timers done");

      // critical alert with 8 ticks to assert, 4 to release
      wr(8'h4a, 8'h90);
      wr(8'h4f, 8'h13);
      wr(8'h49, 8'h21);
      rd(8'h35, 8'h49);
      sysPowerInput = 8'ha0;
      cyc(5);
      check(regulatorOverheatAlertN, 12'h001, "early alert");
      sysPowerInput = 8'h00;
      cyc(1);
      sysPowerInput = 8'ha0; // a dip restarts the wait
      cyc(6);
      check(regulatorOverheatAlertN, 12'h001, "restart");
      cyc(6);
      check(regulatorOverheatAlertN, 12'h000, "alert");
      sysPowerInput = 8'h00;
      cyc(2);
      check(regulatorOverheatAlertN, 12'h000, "early release");
      cyc(6);
      check(regulatorOverheatAlertN, 12'h001, "release");
      wr(8'h4f, 8'h00);
      wr(8'h49, 8'h00);
      sysPowerInput = 8'h90; // equal is not above
      cyc(3);
      check(regulatorOverheatAlertN, 12'h001, "equal level");
      sysPowerInput = 8'h91;
      cyc(2);
      check(regulatorOverheatAlertN, 12'h000, "no debounce");
      sysPowerInput = 8'h00;
      cyc(3);
      check(regulatorOverheatAlertN, 12'h001, "no debounce");
      $display("test critical alert done");

      // limit events at the 800 ns pin rate, unrelated phase
      k = ($random(seed) & 7) + 3;
      #37;
      repeat (k) begin
         #400 cycleCurrentLimitPin = 1'b1;
         #400 cycleCurrentLimitPin = 1'b0;
      end
      cyc(6);
      rd(8'h5c, 8'(k));
      rd(8'h5c, 8'(k));
      $display("test event counter done");

      // both voltage tables, edge codes then random ones
      for (int i = 0; i < 10; i++) begin
         code = (i == 0) ? 8'h00 : (i == 1) ? 8'h01 : (i == 2) ? 8'hff :
                8'($random(seed));
         for (int c = 0; c < 2; c++) begin
            voltageCode = code;
            coarseTable = c[0];
            cyc(2);
            check(voltageMv, vexp(code, c), "millivolts");
         end
      end
      $display("test voltage tables done");

      // second reset in mid-run
      rst_n = 1'b0;
      cyc(2);
      check(multiRegulatorConfig, 12'h001, "cfg in reset");
      check(regulatorOverheatAlertN, 12'h001, "alert in reset");
      rst_n = 1'b1;
      cyc(3);
      rd(8'h34, 8'h01);
      rd(8'h4a, 8'h00);
      $display("test second reset done");
      report_and_stop;
   end
endmodule

// File: vpm_bus_master.sv
`timescale 1ns/10ps
// processor side of the register port: one access at a time
module vpm_bus_master (
   input wire logic sys_clk,
   output vpm_pkg::vpm_req_type regReq,
   input wire logic [7:0] regRdData,
   input wire logic regRdValid
);
   import vpm_pkg::*;

   // idle bus at time zero
   initial begin
      regReq = '0;
   end

   // write: raised after a falling edge, held across one rising edge
   task automatic doWrite(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      regReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge sys_clk);
      // released fields show the inverse, so stale values never look valid
      regReq <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask

   // read: answer is taken in the cycle after the taking edge
   task automatic doRead(input logic [7:0] a, output logic [7:0] d,
                         output logic ok);
      @(negedge sys_clk);
      regReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h5a};
      @(negedge sys_clk);
      ok = regRdValid;
      d = regRdData;
      regReq <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'ha5};
   endtask
endmodule

// File: vpm_pkg.sv
package vpm_pkg;
   // register indices of this bank
   localparam logic [7:0] VPM_ADDR_MULTI_CFG = 8'h34;
   localparam logic [7:0] VPM_ADDR_WRITE_PTR = 8'h35;
   localparam logic [7:0] VPM_ADDR_DBC_CLR = 8'h49;
   localparam logic [7:0] VPM_ADDR_CRIT_LVL = 8'h4a;
   localparam logic [7:0] VPM_ADDR_WARN2_LVL = 8'h4b;
   localparam logic [7:0] VPM_ADDR_WARN1_LVL = 8'h4c;
   localparam logic [7:0] VPM_ADDR_WARN2_TIME = 8'h4d;
   localparam logic [7:0] VPM_ADDR_WARN1_TIME = 8'h4e;
   localparam logic [7:0] VPM_ADDR_DBC_SET = 8'h4f;
   localparam logic [7:0] VPM_ADDR_EXTRA_ICC = 8'h50;
   localparam logic [7:0] VPM_ADDR_CLIM_CNT = 8'h5c;

   // reset values, and the top 8-bit code where counts saturate
   localparam logic [7:0] VPM_RST_MULTI_CFG = 8'h01;
   localparam logic [7:0] VPM_RST_ZERO = 8'h00;
   localparam logic [7:0] VPM_CODE_MAX = 8'hff;

   // mantissa / exponent field layout
   localparam int VPM_MANT_LSB = 4;
   localparam int VPM_EXP_LSB = 0;
   localparam int VPM_FIELD_W = 4;
   localparam logic [3:0] VPM_FIELD_MAX = 4'hf;

   // linear tick count wide enough for 15 << 15
   localparam int VPM_CNT_W = 19;
   localparam logic [VPM_CNT_W-1:0] VPM_CNT_MAX = 19'h78000;

   // time base: tick period in ns, derived cycles at the clock rate
   localparam int VPM_CLK_NS = 100;
   localparam int VPM_TICK_NS = 1000;
   localparam int VPM_TICK_CYC = (VPM_TICK_NS + VPM_CLK_NS - 1) / VPM_CLK_NS;

   // voltage tables in mV
   localparam logic [11:0] VPM_FINE_BASE_MV = 12'h0fa;
   localparam logic [11:0] VPM_FINE_STEP_MV = 12'h005;
   localparam logic [11:0] VPM_COARSE_BASE_MV = 12'h0c8;
   localparam logic [11:0] VPM_COARSE_STEP_MV = 12'h00a;

   // one register access from the serial bus engine
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } vpm_req_type;

   // critical comparator debounce states
   typedef enum logic [3:0] {
      VPM_ST_LOW = 4'b0001,
      VPM_ST_ASSERTING = 4'b0010,
      VPM_ST_HIGH = 4'b0100,
      VPM_ST_DEASSERTING = 4'b1000
   } vpm_crit_state_type;

   // mantissa << exponent as a linear tick count
   function automatic logic [VPM_CNT_W-1:0] vpm_decode(input logic [7:0] v);
      logic [VPM_CNT_W-1:0] m;
      m = VPM_CNT_W'(v[VPM_MANT_LSB +: VPM_FIELD_W]);
      return m << v[VPM_EXP_LSB +: VPM_FIELD_W];
   endfunction

   // smallest exponent that fits the mantissa in one nibble
   function automatic logic [7:0] vpm_encode(input logic [VPM_CNT_W-1:0] c);
      logic [7:0] r;
      logic [VPM_CNT_W-1:0] t;
      r = {VPM_FIELD_MAX, VPM_FIELD_MAX};
      t = '0;
      for (int e = 15; e >= 0; e--) begin
         t = c >> e;
         if (t <= VPM_CNT_W'(VPM_FIELD_MAX)) begin
            r = {t[3:0], 4'(e)};
         end
      end
      return r;
   endfunction

   // voltage code to millivolts, code zero is zero volts
   function automatic logic [11:0] vpm_code_to_mv(input logic [7:0] code,
                                                   input logic coarse);
      logic [11:0] n;
      n = 12'(code) - 12'h001;
      if (code == VPM_RST_ZERO) begin
         return 12'h000;
      end
      if (coarse) begin
         return VPM_COARSE_BASE_MV + 12'(n * VPM_COARSE_STEP_MV);
      end
      return VPM_FINE_BASE_MV + 12'(n * VPM_FINE_STEP_MV);
   endfunction
endpackage

// File: vpm_power_monitor_regs.sv
`timescale 1ns/10ps
// Operation
// RL1: read/write multi-regulator config, resets to 01h
// RL2: read-only main write pointer register
// RL3: overheat alert while input exceeds critical level
// RL4: assert debounce delays alert assertion
// RL5: deassert debounce delays alert release
// RL6: durations and counters use mantissa/exponent nibbles
// RL7: two warning levels compared with input
// RL8: per-level read-only time-above counters
// RL9: counters clear on read or changed level
// RL10: counters saturate, never wrap
// RL11: counters hold in deepest low-power state
// RL12: extra current capability scaling in low bits
// RL13: count cycle current limit trigger events
// RL14: voltage code tables, fine and coarse
// RL15: counters advance on fixed internal time base
module vpm_power_monitor_regs #(
   parameter logic [1:0] ICC_SCALE = 2'b00, // 00: 1 A/step, 01: 2 A/step
   parameter int TICK_CYC = vpm_pkg::VPM_TICK_CYC
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input vpm_pkg::vpm_req_type regReq,
   output logic [7:0] regRdData,
   output logic regRdValid,
   input wire logic [7:0] sysPowerInput,
   input wire logic deepestLowPowerState,
   input wire logic cycleCurrentLimitPin,
   input wire logic [7:0] voltageCode,
   input wire logic coarseTable,
   output logic [11:0] voltageMv,
   output logic [7:0] multiRegulatorConfig,
   output logic regulatorOverheatAlertN
);
   import vpm_pkg::*;

   // refuse settings the logic cannot serve
   initial begin
      // the tick divider is 16 bits wide
      if (TICK_CYC < 1 || TICK_CYC > 65536 || ICC_SCALE > 2'b01) begin
         $error("vpm_power_monitor_regs: bad parameter");
      end
   end

   // reset release synchroniser
   logic rstMeta_q;
   logic rstSyncN; // the only reset used below

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta_q <= 1'b0;
         rstSyncN <= 1'b0;
      end else begin
         rstMeta_q <= 1'b1;
         rstSyncN <= rstMeta_q;
      end
   end

   // ---------------- time base ----------------
   logic [15:0] tickCnt_q; // divides sys_clk down to the tick rate
   logic [15:0] tickCnt_d;
   logic tick; // one-cycle enable

   always_comb begin
      tick = (tickCnt_q == 16'(TICK_CYC - 1));
      tickCnt_d = tick ? 16'h0000 : tickCnt_q + 16'h0001;
   end

   always_ff @(posedge sys_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         tickCnt_q <= 16'h0000;
      end else begin
         tickCnt_q <= tickCnt_d;
      end
   end

   // ---------------- register file ----------------
   logic [7:0] multiCfg_q, multiCfg_d; // bus sharing / power-good config
   logic [7:0] writePtr_q, writePtr_d; // last main-space write index
   logic [7:0] dbcClr_q, dbcClr_d; // deassert debounce code
   logic [7:0] dbcSet_q, dbcSet_d; // assert debounce code
   logic [7:0] critLvl_q, critLvl_d; // critical comparator level
   logic [7:0] warn2Lvl_q, warn2Lvl_d; // warning 2 level
   logic [7:0] warn1Lvl_q, warn1Lvl_d; // warning 1 level
   logic [7:0] rdData_q, rdData_d; // read answer
   logic rdValid_q;
   logic [7:0] warn2Time; // coded counters from the timers
   logic [7:0] warn1Time;
   logic [7:0] climCnt_q; // cycle current limit events
   logic warn2Clear;
   logic warn1Clear;

   // a write to a level clears its timer only when the value changes;
   // rewriting the same level keeps the accumulated time
   always_comb begin
      warn2Clear = (regReq.rd && regReq.addr == VPM_ADDR_WARN2_TIME) ||
                   (regReq.wr && regReq.addr == VPM_ADDR_WARN2_LVL &&
                    regReq.wdata != warn2Lvl_q); // RL9
      warn1Clear = (regReq.rd && regReq.addr == VPM_ADDR_WARN1_TIME) ||
                   (regReq.wr && regReq.addr == VPM_ADDR_WARN1_LVL &&
                    regReq.wdata != warn1Lvl_q); // RL9
   end

   // writable registers and pointer update
   always_comb begin
      multiCfg_d = multiCfg_q;
      dbcClr_d = dbcClr_q;
      dbcSet_d = dbcSet_q;
      critLvl_d = critLvl_q;
      warn2Lvl_d = warn2Lvl_q;
      warn1Lvl_d = warn1Lvl_q;
      writePtr_d = writePtr_q;
      if (regReq.wr) begin
         writePtr_d = regReq.addr; // RL2
         case (regReq.addr)
            VPM_ADDR_MULTI_CFG: begin
               multiCfg_d = regReq.wdata; // RL1
            end
            VPM_ADDR_DBC_CLR: begin
               dbcClr_d = regReq.wdata; // RL5
            end
            VPM_ADDR_DBC_SET: begin
               dbcSet_d = regReq.wdata; // RL4
            end
            VPM_ADDR_CRIT_LVL: begin
               critLvl_d = regReq.wdata; // RL3
            end
            VPM_ADDR_WARN2_LVL: begin
               warn2Lvl_d = regReq.wdata; // RL7
            end
            VPM_ADDR_WARN1_LVL: begin
               warn1Lvl_d = regReq.wdata; // RL7
            end
            default: begin
               // read-only or unmapped: write ignored
            end
         endcase
      end
   end

   // read mux; unmapped indices answer zero
   always_comb begin
      case (regReq.addr)
         VPM_ADDR_MULTI_CFG: rdData_d = multiCfg_q;
         VPM_ADDR_WRITE_PTR: rdData_d = writePtr_q; // RL2
         VPM_ADDR_DBC_CLR: rdData_d = dbcClr_q;
         VPM_ADDR_CRIT_LVL: rdData_d = critLvl_q;
         VPM_ADDR_WARN2_LVL: rdData_d = warn2Lvl_q;
         VPM_ADDR_WARN1_LVL: rdData_d = warn1Lvl_q;
         VPM_ADDR_WARN2_TIME: rdData_d = warn2Time; // RL8
         VPM_ADDR_WARN1_TIME: rdData_d = warn1Time; // RL8
         VPM_ADDR_DBC_SET: rdData_d = dbcSet_q;
         VPM_ADDR_EXTRA_ICC: rdData_d = {6'h00, ICC_SCALE}; // RL12
         VPM_ADDR_CLIM_CNT: rdData_d = climCnt_q; // RL13
         default: rdData_d = VPM_RST_ZERO;
      endcase
      if (!regReq.rd) begin
         rdData_d = rdData_q;
      end
   end

   always_ff @(posedge sys_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         multiCfg_q <= VPM_RST_MULTI_CFG; // RL1
         writePtr_q <= VPM_RST_ZERO;
         dbcClr_q <= VPM_RST_ZERO;
         dbcSet_q <= VPM_RST_ZERO;
         critLvl_q <= VPM_RST_ZERO;
         warn2Lvl_q <= VPM_RST_ZERO;
         warn1Lvl_q <= VPM_RST_ZERO;
         rdData_q <= VPM_RST_ZERO;
         rdValid_q <= 1'b0;
      end else begin
         multiCfg_q <= multiCfg_d;
         writePtr_q <= writePtr_d;
         dbcClr_q <= dbcClr_d;
         dbcSet_q <= dbcSet_d;
         critLvl_q <= critLvl_d;
         warn2Lvl_q <= warn2Lvl_d;
         warn1Lvl_q <= warn1Lvl_d;
         rdData_q <= rdData_d;
         rdValid_q <= regReq.rd;
      end
   end

   assign regRdData = rdData_q;
   assign regRdValid = rdValid_q;
   assign multiRegulatorConfig = multiCfg_q;

   // ---------------- warning timers ----------------
   vpm_warn_timer u_warn2 (
      .sys_clk(sys_clk),
      .rstN(rstSyncN),
      .tick(tick),
      .above(sysPowerInput > warn2Lvl_q), // RL7
      .hold(deepestLowPowerState),
      .clear(warn2Clear),
      .timeCode(warn2Time)
   );

   vpm_warn_timer u_warn1 (
      .sys_clk(sys_clk),
      .rstN(rstSyncN),
      .tick(tick),
      .above(sysPowerInput > warn1Lvl_q), // RL7
      .hold(deepestLowPowerState),
      .clear(warn1Clear),
      .timeCode(warn1Time)
   );

   // ---------------- critical comparator ----------------
   vpm_crit_state_type st_q, st_d;
   logic [VPM_CNT_W-1:0] dbcCnt_q, dbcCnt_d; // ticks spent debouncing
   logic alertN_q, alertN_d;
   logic critAbove;

   // a zero debounce code switches in the very next cycle
   always_comb begin
      critAbove = sysPowerInput > critLvl_q; // RL3
      st_d = st_q;
      dbcCnt_d = dbcCnt_q;
      case (st_q)
         VPM_ST_LOW: begin
            dbcCnt_d = '0;
            if (critAbove) begin
               st_d = (vpm_decode(dbcSet_q) == '0) ? VPM_ST_HIGH
                                                   : VPM_ST_ASSERTING;
            end
         end
         VPM_ST_ASSERTING: begin
            if (!critAbove) begin
               st_d = VPM_ST_LOW; // dip restarts the assert window
            end else if (tick) begin
               dbcCnt_d = dbcCnt_q + VPM_CNT_W'(1);
               if (dbcCnt_d >= vpm_decode(dbcSet_q)) begin
                  st_d = VPM_ST_HIGH; // RL4
               end
            end
         end
         VPM_ST_HIGH: begin
            dbcCnt_d = '0;
            if (!critAbove) begin
               st_d = (vpm_decode(dbcClr_q) == '0) ? VPM_ST_LOW
                                                   : VPM_ST_DEASSERTING;
            end
         end
         VPM_ST_DEASSERTING: begin
            if (critAbove) begin
               st_d = VPM_ST_HIGH;
               dbcCnt_d = '0;
            end else if (tick) begin
               dbcCnt_d = dbcCnt_q + VPM_CNT_W'(1);
               if (dbcCnt_d >= vpm_decode(dbcClr_q)) begin
                  st_d = VPM_ST_LOW; // RL5
               end
            end
         end
         default: begin
            st_d = VPM_ST_LOW;
            dbcCnt_d = '0;
         end
      endcase
      alertN_d = !(st_d == VPM_ST_HIGH || st_d == VPM_ST_DEASSERTING); // RL3
   end

   always_ff @(posedge sys_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         st_q <= VPM_ST_LOW;
         dbcCnt_q <= '0;
         alertN_q <= 1'b1;
      end else begin
         st_q <= st_d;
         dbcCnt_q <= dbcCnt_d;
         alertN_q <= alertN_d;
      end
   end

   assign regulatorOverheatAlertN = alertN_q;

   // ---------------- cycle limit events ----------------
   // the limit flag is asynchronous: two flops, then edge detect
   logic climMeta_q, climSync_q, climPrev_q;
   logic [7:0] climCnt_d;
   logic climEdge;

   always_comb begin
      climEdge = climSync_q && !climPrev_q;
      climCnt_d = climCnt_q;
      if (climEdge && climCnt_q != VPM_CODE_MAX) begin
         climCnt_d = climCnt_q + 8'h01; // RL13
      end
   end

   always_ff @(posedge sys_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         climMeta_q <= 1'b0;
         climSync_q <= 1'b0;
         climPrev_q <= 1'b0;
         climCnt_q <= VPM_RST_ZERO;
      end else begin
         climMeta_q <= cycleCurrentLimitPin;
         climSync_q <= climMeta_q;
         climPrev_q <= climSync_q;
         climCnt_q <= climCnt_d;
      end
   end

   // ---------------- voltage code decode ----------------
   logic [11:0] voltMv_q;

   always_ff @(posedge sys_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         voltMv_q <= 12'h000;
      end else begin
         voltMv_q <= vpm_code_to_mv(voltageCode, coarseTable); // RL14
      end
   end

   assign voltageMv = voltMv_q;

   // ---------------- checks ----------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstSyncN);

   property p_cfg_write;
      regReq.wr && regReq.addr == VPM_ADDR_MULTI_CFG
         |=> multiCfg_q == $past(regReq.wdata);
   endproperty
   a_cfg_write: assert property (p_cfg_write) // RL1
      else $error("config write lost");

   property p_ptr;
      regReq.wr |=> writePtr_q == $past(regReq.addr);
   endproperty
   a_ptr: assert property (p_ptr) // RL2
      else $error("write pointer wrong");

   property p_alert_cause;
      $fell(alertN_q) |-> $past(critAbove);
   endproperty
   a_alert_cause: assert property (p_alert_cause) // RL3
      else $error("alert without critical level");

   sequence s_above_from_low;
      // a zero mantissa also decodes to no wait at all
      st_q == VPM_ST_LOW && critAbove && vpm_decode(dbcSet_q) != '0;
   endsequence
   property p_assert_delay;
      s_above_from_low |=> alertN_q;
   endproperty
   a_assert_delay: assert property (p_assert_delay) // RL4
      else $error("alert skipped assert debounce");

   property p_release;
      $rose(alertN_q) |-> $past(!critAbove);
   endproperty
   a_release: assert property (p_release) // RL5
      else $error("alert released while above");

   property p_clim;
      climEdge && climCnt_q != VPM_CODE_MAX
         |=> climCnt_q == $past(climCnt_q) + 1;
   endproperty
   a_clim: assert property (p_clim) // RL13
      else $error("limit event not counted");

   property p_icc;
      regReq.rd && regReq.addr == VPM_ADDR_EXTRA_ICC
         |=> regRdValid && regRdData == {6'h00, ICC_SCALE};
   endproperty
   a_icc: assert property (p_icc) // RL12
      else $error("capability read wrong");
endmodule

// File: vpm_warn_timer.sv
`timescale 1ns/10ps
module vpm_warn_timer (
   input wire logic sys_clk,
   input wire logic rstN,
   input wire logic tick,
   input wire logic above,
   input wire logic hold,
   input wire logic clear,
   output logic [7:0] timeCode
);
   import vpm_pkg::*;

   logic [VPM_CNT_W-1:0] count_q; // linear ticks spent above the level
   logic [VPM_CNT_W-1:0] count_d;
   logic [7:0] code_q; // encoded copy seen by the register file
   logic inc;

   // counting only happens on time-base ticks while above the level
   assign inc = tick && above && !hold; // RL15

   // next count: hold wins over everything, a tick landing on a clear
   // survives as one tick so no time above the level is lost
   always_comb begin
      count_d = count_q;
      if (hold) begin
         count_d = count_q; // RL11
      end else if (clear) begin
         count_d = inc ? VPM_CNT_W'(1) : '0; // RL9
      end else if (inc && count_q != VPM_CNT_MAX) begin
         count_d = count_q + VPM_CNT_W'(1); // RL10
      end
   end

   // register both the linear count and its coded form
   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         count_q <= '0;
         code_q <= VPM_RST_ZERO;
      end else begin
         count_q <= count_d;
         code_q <= vpm_encode(count_d); // RL6
      end
   end

   assign timeCode = code_q;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstN);

   property p_clear_zero;
      clear && !hold && !inc |=> count_q == '0;
   endproperty
   a_clear_zero: assert property (p_clear_zero) // RL9
      else $error("warn timer not cleared");

   property p_saturate;
      count_q == VPM_CNT_MAX && !clear && !hold |=> count_q == VPM_CNT_MAX;
   endproperty
   a_saturate: assert property (p_saturate) // RL10
      else $error("warn timer wrapped");

   property p_hold;
      hold |=> count_q == $past(count_q) && code_q == $past(code_q);
   endproperty
   a_hold: assert property (p_hold) // RL11
      else $error("warn timer moved in low power");

   property p_advance;
      inc && !clear && count_q != VPM_CNT_MAX
         |=> count_q == $past(count_q) + 1;
   endproperty
   a_advance: assert property (p_advance) // RL15
      else $error("warn timer did not advance");
endmodule
